// ==== hw/display_parallel_bus_master.sv ====
// Purpose: 80-series 16-bit parallel bus master toward a display controller
// Assumes: Inputs synchronous to sys_clk_i; one request at a time
// Notes:   Data bus split into in/out/enable; wire resolved outside
`timescale 1ns/1ps

// Contract
// RULE1: Select held low for every access
// RULE2: Status read: select0 rs0 rd0 wr1
// RULE3: Index write: select0 rs0 rd1 wr0
// RULE4: Memory read: select0 rs1 rd0 wr1
// RULE5: Data write: select0 rs1 rd1 wr0
// RULE6: All transfers over one 16-bit bus
// RULE7: Register select low index, high data
// RULE8: Write strobe low while word presented
// RULE9: Read strobe low, capture bus word
// RULE10: Write low 50, high 50, cycle 100
// RULE11: Read low 150, high 150, cycle 300
// RULE12: Pulse panel reset low, then release
// RULE13: Boost enable drives DC-DC converter
// RULE14: Release data bus when not writing
// RULE15: Never both strobes low; idle high
module display_parallel_bus_master (
    input  wire logic                                sys_clk_i,
    input  wire logic                                rst_b_i,
    input  wire logic                                req_valid_i,
    input  wire panel_bus_pkg::cmd_t                 req_cmd_i,
    input  wire logic [panel_bus_pkg::DATA_W-1:0]    req_wdata_i,
    input  wire logic                                boost_on_i,
    input  wire logic                                panel_reinit_i,
    output logic                                     req_ready_o,
    output logic                                     rsp_valid_o,
    output logic [panel_bus_pkg::DATA_W-1:0]         rsp_rdata_o,
    output logic                                     init_done_o,
    output logic                                     panel_select_b_o,
    output logic                                     register_select_o,
    output logic                                     fetch_strobe_b_o,
    output logic                                     store_strobe_b_o,
    output logic                                     panel_reset_b_o,
    output logic                                     boost_enable_o,
    input  wire logic [panel_bus_pkg::DATA_W-1:0]    panel_data_bus_i,
    output logic [panel_bus_pkg::DATA_W-1:0]         panel_data_bus_o,
    output logic                                     panel_data_bus_oe_o
);

    // =====================================================
    // Reset release
    logic rst_sync1_ff;
    logic rst_b_ff;

    // Assert at once, release on the clock so no flop sees a runt edge
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync1_ff <= 1'b0;
            rst_b_ff     <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_b_ff     <= rst_sync1_ff;
        end
    end

    // =====================================================
    // Timing helpers
    function automatic logic [panel_bus_pkg::CNT_W-1:0] phase_len(
        input logic is_read, input logic low_phase);
        int unsigned lo;
        int unsigned hi;
        int unsigned tot;
        lo  = is_read ? panel_bus_pkg::FETCH_LOW_CYC  : panel_bus_pkg::STORE_LOW_CYC;
        hi  = is_read ? panel_bus_pkg::FETCH_HIGH_CYC : panel_bus_pkg::STORE_HIGH_CYC;
        tot = is_read ? panel_bus_pkg::FETCH_CYCLE_CYC : panel_bus_pkg::STORE_CYCLE_CYC;
        // Stretch the high phase so low plus high meets the full cycle
        if (lo + hi < tot) begin
            hi = tot - lo;
        end
        return low_phase ? panel_bus_pkg::CNT_W'(lo) : panel_bus_pkg::CNT_W'(hi);
    endfunction

    // Access still framed by select: strobe phase and its recovery
    function automatic logic in_access(input panel_bus_pkg::state_t st);
        return (st == panel_bus_pkg::ST_STROBE) || (st == panel_bus_pkg::ST_RECOVER);
    endfunction

    // In idle the bit of the request being taken, else the held one
    function automatic logic live_bit(
        input panel_bus_pkg::state_t st,
        input logic                  req_bit,
        input logic                  held_bit);
        return (st == panel_bus_pkg::ST_IDLE) ? req_bit : held_bit;
    endfunction

    // =====================================================
    // State
    panel_bus_pkg::state_t              state_ff;
    panel_bus_pkg::state_t              nxt_state;
    logic [panel_bus_pkg::CNT_W-1:0]    cnt_ff;
    logic [panel_bus_pkg::CNT_W-1:0]    nxt_cnt;
    logic                               cnt_done;
    logic                               is_read_ff;
    logic                               rs_ff;
    logic [panel_bus_pkg::DATA_W-1:0]   wdata_ff;
    logic                               take_req;

    // Counter holds the phase length less one; zero ends the phase
    assign cnt_done    = (cnt_ff == panel_bus_pkg::CNT_ZERO);
    assign req_ready_o = (state_ff == panel_bus_pkg::ST_IDLE);
    assign take_req    = req_ready_o && req_valid_i;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 1'b1;
        unique case (state_ff)
            panel_bus_pkg::ST_PANEL_RST: begin
                if (cnt_done) begin
                    nxt_state = panel_bus_pkg::ST_SETTLE;
                    nxt_cnt   = panel_bus_pkg::CNT_W'(panel_bus_pkg::PANEL_RST_SETTLE_CYC - 1);
                end
            end
            panel_bus_pkg::ST_SETTLE: begin
                if (cnt_done) begin
                    nxt_state = panel_bus_pkg::ST_IDLE;
                end
            end
            panel_bus_pkg::ST_IDLE: begin
                // Reinit wins over a waiting request; ready stays high that cycle, so the request is lost
                if (panel_reinit_i) begin
                    nxt_state = panel_bus_pkg::ST_PANEL_RST; // RULE12
                    nxt_cnt   = panel_bus_pkg::CNT_W'(panel_bus_pkg::PANEL_RST_LOW_CYC - 1);
                end else if (req_valid_i) begin
                    nxt_state = panel_bus_pkg::ST_STROBE;
                    nxt_cnt   = phase_len(req_cmd_i[1], 1'b1) - 1'b1; // RULE10 RULE11
                end
            end
            panel_bus_pkg::ST_STROBE: begin
                if (cnt_done) begin
                    nxt_state = panel_bus_pkg::ST_RECOVER;
                    nxt_cnt   = phase_len(is_read_ff, 1'b0) - 1'b1; // RULE10 RULE11
                end
            end
            panel_bus_pkg::ST_RECOVER: begin
                if (cnt_done) begin
                    nxt_state = panel_bus_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // Reset lands in the panel reset pulse so every power-up reinitialises the panel
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            state_ff <= panel_bus_pkg::ST_PANEL_RST;
            cnt_ff   <= panel_bus_pkg::CNT_W'(panel_bus_pkg::PANEL_RST_LOW_CYC - 1);
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // =====================================================
    // Request capture
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            is_read_ff <= 1'b0;
        end else if (take_req && !panel_reinit_i) begin
            is_read_ff <= req_cmd_i[1];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            rs_ff <= 1'b0;
        end else if (take_req && !panel_reinit_i) begin
            rs_ff <= req_cmd_i[0]; // RULE7
        end
    end

    // Word kept for the whole access; the input may move after the take
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            wdata_ff <= panel_bus_pkg::DATA_RST;
        end else if (take_req && !panel_reinit_i) begin
            wdata_ff <= req_wdata_i;
        end
    end

    // =====================================================
    // Pin drive, all registered
    logic strobe_phase;
    logic nxt_strobe;
    logic access_ahead;
    logic live_read;
    assign strobe_phase = (nxt_state == panel_bus_pkg::ST_STROBE);
    assign nxt_strobe   = strobe_phase;
    assign access_ahead = in_access(nxt_state);
    assign live_read    = live_bit(state_ff, req_cmd_i[1], is_read_ff);

    // Select spans strobe and recovery so the cycle stays framed
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            panel_select_b_o <= 1'b1;
        end else begin
            panel_select_b_o <= !access_ahead; // RULE1
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            register_select_o <= 1'b0;
        end else begin
            register_select_o <= (state_ff == panel_bus_pkg::ST_IDLE && take_req)
                                 ? req_cmd_i[0] : rs_ff; // RULE7
        end
    end

    // Read flag fixes which strobe may fall: never both
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            fetch_strobe_b_o <= 1'b1;
        end else begin
            fetch_strobe_b_o <= !(nxt_strobe && live_read); // RULE2 RULE4 RULE9 RULE15
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            store_strobe_b_o <= 1'b1;
        end else begin
            store_strobe_b_o <= !(nxt_strobe && !live_read); // RULE3 RULE5 RULE8 RULE15
        end
    end

    // Data held through recovery for hold time on the rising strobe
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            panel_data_bus_o <= panel_bus_pkg::DATA_RST;
        end else begin
            panel_data_bus_o <= (state_ff == panel_bus_pkg::ST_IDLE) ? req_wdata_i
                                : wdata_ff; // RULE6 RULE8
        end
    end

    // Drivers off on reads and between accesses, so the panel never fights us
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            panel_data_bus_oe_o <= 1'b0;
        end else begin
            panel_data_bus_oe_o <= access_ahead && !live_read; // RULE14
        end
    end

    // =====================================================
    // Read capture at the end of the low phase
    logic fetch_last;
    assign fetch_last = (state_ff == panel_bus_pkg::ST_STROBE) && cnt_done && is_read_ff;

    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            rsp_valid_o <= 1'b0;
        end else begin
            rsp_valid_o <= fetch_last;
        end
    end

    // Sampled on the last low clock, after the panel had the full low time
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            rsp_rdata_o <= panel_bus_pkg::DATA_RST;
        end else if (fetch_last) begin
            rsp_rdata_o <= panel_data_bus_i; // RULE9 RULE6
        end
    end

    // =====================================================
    // Panel reset and converter enable
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            panel_reset_b_o <= 1'b0;
        end else begin
            panel_reset_b_o <= (nxt_state != panel_bus_pkg::ST_PANEL_RST); // RULE12
        end
    end

    // Converter follows its input only; no sequencing against the panel reset
    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            boost_enable_o <= 1'b0;
        end else begin
            boost_enable_o <= boost_on_i; // RULE13
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            init_done_o <= 1'b0;
        end else begin
            init_done_o <= (nxt_state != panel_bus_pkg::ST_PANEL_RST) &&
                           (nxt_state != panel_bus_pkg::ST_SETTLE);
        end
    end

endmodule

// ==== hw/panel_bus_pkg.sv ====
// Purpose: Constants for the 80-series display bus master
// Assumes: 25 MHz system clock, 40 ns period
// Notes:   Times in ns; cycle counts derived and rounded up
package panel_bus_pkg;

    // =====================================================
    // Clock
    localparam int unsigned CLK_PERIOD_NS = 40;

    // =====================================================
    // Bus timing (least times)
    localparam int unsigned STORE_LOW_TIME_NS   = 50;
    localparam int unsigned STORE_HIGH_TIME_NS  = 50;
    localparam int unsigned STORE_CYCLE_TIME_NS = 100;
    localparam int unsigned FETCH_LOW_TIME_NS   = 150;
    localparam int unsigned FETCH_HIGH_TIME_NS  = 150;
    localparam int unsigned FETCH_CYCLE_TIME_NS = 300;

    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int unsigned STORE_LOW_CYC   = ns_to_cyc(STORE_LOW_TIME_NS);
    localparam int unsigned STORE_HIGH_CYC  = ns_to_cyc(STORE_HIGH_TIME_NS);
    localparam int unsigned STORE_CYCLE_CYC = ns_to_cyc(STORE_CYCLE_TIME_NS);
    localparam int unsigned FETCH_LOW_CYC   = ns_to_cyc(FETCH_LOW_TIME_NS);
    localparam int unsigned FETCH_HIGH_CYC  = ns_to_cyc(FETCH_HIGH_TIME_NS);
    localparam int unsigned FETCH_CYCLE_CYC = ns_to_cyc(FETCH_CYCLE_TIME_NS);

    // Panel reset pulse and settle after release (chosen values)
    localparam int unsigned PANEL_RST_LOW_TIME_NS    = 10000;
    localparam int unsigned PANEL_RST_SETTLE_TIME_NS = 10000;
    localparam int unsigned PANEL_RST_LOW_CYC    = ns_to_cyc(PANEL_RST_LOW_TIME_NS);
    localparam int unsigned PANEL_RST_SETTLE_CYC = ns_to_cyc(PANEL_RST_SETTLE_TIME_NS);

    // =====================================================
    // Widths and reset values
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W  = 10;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ZERO = 10'h000;

    // =====================================================
    // Command: bit1 = read, bit0 = register_select level
    typedef enum logic [1:0] {
        CMD_STATUS_READ  = 2'h2,
        CMD_INDEX_WRITE  = 2'h0,
        CMD_MEMORY_READ  = 2'h3,
        CMD_DATA_WRITE   = 2'h1
    } cmd_t;

    typedef enum logic [4:0] {
        ST_PANEL_RST = 5'h01,
        ST_SETTLE    = 5'h02,
        ST_IDLE      = 5'h04,
        ST_STROBE    = 5'h08,
        ST_RECOVER   = 5'h10
    } state_t;

endpackage

// ==== dv/display_parallel_bus_master_assertions.sv ====
// Purpose: Port checks of the display bus master
// Assumes: Bound to the top module, 25 MHz walk
// Notes:   Counts are the cycle figures of the hand-over walk
`timescale 1ns/1ps
// ====================
// Checker
module display_parallel_bus_master_assertions (
    input wire logic                 sys_clk_i,
    input wire logic                 rst_b_i,
    input wire logic                 req_valid_i,
    input wire panel_bus_pkg::cmd_t  req_cmd_i,
    input wire logic [15:0]          req_wdata_i,
    input wire logic                 boost_on_i,
    input wire logic                 panel_reinit_i,
    input wire logic                 req_ready_o,
    input wire logic                 rsp_valid_o,
    input wire logic [15:0]          rsp_rdata_o,
    input wire logic                 init_done_o,
    input wire logic                 panel_select_b_o,
    input wire logic                 register_select_o,
    input wire logic                 fetch_strobe_b_o,
    input wire logic                 store_strobe_b_o,
    input wire logic                 panel_reset_b_o,
    input wire logic                 boost_enable_o,
    input wire logic [15:0]          panel_data_bus_i,
    input wire logic [15:0]          panel_data_bus_o,
    input wire logic                 panel_data_bus_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic take;
    assign take = req_ready_o && req_valid_i && !panel_reinit_i;
    sequence s_store; (!store_strobe_b_o)[*2] ##1 store_strobe_b_o[*2]; endsequence
    sequence s_fetch; (!fetch_strobe_b_o)[*4] ##1 fetch_strobe_b_o[*4]; endsequence
    property p_encode;
        take |=> !panel_select_b_o && register_select_o == $past(req_cmd_i[0])
            && fetch_strobe_b_o == !$past(req_cmd_i[1])
            && store_strobe_b_o == $past(req_cmd_i[1]);
    endproperty
    a_encode: assert property (p_encode) else $error("bad strobe code");
    property p_wdata;
        take && !req_cmd_i[1] |=> panel_data_bus_oe_o && panel_data_bus_o == $past(req_wdata_i);
    endproperty
    a_wdata: assert property (p_wdata) else $error("write word not driven");
    property p_hold;
        panel_data_bus_oe_o && $past(panel_data_bus_oe_o)
            |-> $stable(panel_data_bus_o) && $stable(register_select_o);
    endproperty
    a_hold: assert property (p_hold) else $error("write word moved");
    property p_store; $fell(store_strobe_b_o) |-> s_store; endproperty
    a_store: assert property (p_store) else $error("write pulse short");
    property p_fetch; $fell(fetch_strobe_b_o) |-> s_fetch; endproperty
    a_fetch: assert property (p_fetch) else $error("read pulse short");
    property p_release;
        panel_select_b_o || !fetch_strobe_b_o |-> !panel_data_bus_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("bus driven off write");
    property p_idle;
        panel_select_b_o |-> fetch_strobe_b_o && store_strobe_b_o;
    endproperty
    a_idle: assert property (p_idle) else $error("strobe without select");
    property p_excl; fetch_strobe_b_o || store_strobe_b_o; endproperty
    a_excl: assert property (p_excl) else $error("both strobes low");
    property p_rsp;
        rsp_valid_o |-> $rose(fetch_strobe_b_o) && rsp_rdata_o == $past(panel_data_bus_i);
    endproperty
    a_rsp: assert property (p_rsp) else $error("read word not captured");
    property p_prst;
        !panel_reset_b_o |-> panel_select_b_o && !req_ready_o && !init_done_o;
    endproperty
    a_prst: assert property (p_prst) else $error("access in panel reset");
    property p_boost; $past(rst_b_i, 4) |-> boost_enable_o == $past(boost_on_i); endproperty
    a_boost: assert property (p_boost) else $error("boost enable lag");
    property p_ready; req_ready_o |-> init_done_o && panel_reset_b_o; endproperty
    a_ready: assert property (p_ready) else $error("ready before init done");
endmodule

// ==== dv/panel_model.sv ====
// Purpose: Display controller on the far side of the bus
// Assumes: Bus level resolved by the bench
// Notes:   Word valid only two cycles into the read strobe
`timescale 1ns/1ps
module panel_model (
    input wire logic         sys_clk_i,
    input wire logic         select_b_i,
    input wire logic         rs_i,
    input wire logic         fetch_b_i,
    input wire logic         store_b_i,
    input wire logic [15:0]  bus_i,
    output logic [15:0]      bus_o
);
    logic [15:0] idx_ff;
    logic [15:0] mem_ff [256];
    logic [15:0] junk_ff = 16'h5A5A;
    logic        store_q_ff = 1'b1;
    logic [2:0]  low_ff = 3'h0;
    always_ff @(posedge sys_clk_i) begin
        store_q_ff <= store_b_i;
        junk_ff <= ~junk_ff;
        low_ff <= (select_b_i || fetch_b_i) ? 3'h0 : low_ff + 3'h1;
        if (!select_b_i && store_b_i && !store_q_ff) begin
            if (rs_i) mem_ff[idx_ff[7:0]] <= bus_i;
            else idx_ff <= bus_i;
        end
    end
    // Released line toggles so a stale word never passes
    assign bus_o = (select_b_i || fetch_b_i || low_ff < 3'h2) ? junk_ff
                 : rs_i ? mem_ff[idx_ff[7:0]] : idx_ff;
endmodule

// ==== dv/display_parallel_bus_master_test.sv ====
// Purpose: Self-checking bench of the display bus master
// Assumes: Panel model on the far side
// Notes:   Expected read words queued at the take edge
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module display_parallel_bus_master_test;
    logic                sys_clk_i = 1'b0;
    logic                rst_b_i = 1'b0;
    logic                req_valid_i = 1'b0;
    panel_bus_pkg::cmd_t req_cmd_i = panel_bus_pkg::CMD_STATUS_READ;
    logic [15:0]         req_wdata_i = 16'h0000;
    logic                boost_on_i = 1'b0;
    logic                panel_reinit_i = 1'b0;
    logic                req_ready_o, rsp_valid_o, init_done_o, panel_select_b_o;
    logic                register_select_o, fetch_strobe_b_o, store_strobe_b_o;
    logic                panel_reset_b_o, boost_enable_o, panel_data_bus_oe_o;
    logic [15:0]         rsp_rdata_o, panel_data_bus_i, panel_data_bus_o, mdata, idx;
    logic [15:0]         smem [256];
    logic [15:0]         expq [$];
    int                  n_errors = 0;
    int                  checks = 0;
    int                  seed = 32'hd66d;
    initial forever #20 sys_clk_i = ~sys_clk_i;
    assign panel_data_bus_i = panel_data_bus_oe_o ? panel_data_bus_o : mdata;
    display_parallel_bus_master i_dut (.*);
    panel_model i_panel (.sys_clk_i(sys_clk_i), .select_b_i(panel_select_b_o),
        .rs_i(register_select_o), .fetch_b_i(fetch_strobe_b_o),
        .store_b_i(store_strobe_b_o), .bus_i(panel_data_bus_i), .bus_o(mdata));
    always @(posedge sys_clk_i) begin
        if (rsp_valid_o === 1'b1) begin
            if (expq.size() == 0) `CHK(rsp_valid_o, 1'b0)
            else `CHK(rsp_rdata_o, expq.pop_front())
        end
    end
    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Valid stays up between requests; taken on a ready edge
    task automatic req(input panel_bus_pkg::cmd_t c, input logic [15:0] d);
        int n;
        n = 0;
        req_valid_i <= 1'b1;
        req_cmd_i <= c;
        req_wdata_i <= d;
        do begin @(posedge sys_clk_i); n++; end while (req_ready_o !== 1'b1 && n < 600);
        if (n >= 600) n_errors++;
        if (c == panel_bus_pkg::CMD_INDEX_WRITE) idx = d;
        else if (c == panel_bus_pkg::CMD_DATA_WRITE) smem[idx[7:0]] = d;
        else if (c == panel_bus_pkg::CMD_STATUS_READ) expq.push_back(idx);
        else expq.push_back(smem[idx[7:0]]);
    endtask
    initial begin
        #(40 * 5000);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        `CHK(panel_reset_b_o, 1'b0)
        for (int i = 0; i < 16; i++) begin
            boost_on_i <= 1'($random(seed));
            req(panel_bus_pkg::CMD_INDEX_WRITE, 16'($random(seed)));
            req(panel_bus_pkg::CMD_DATA_WRITE, 16'($random(seed)));
            req(panel_bus_pkg::CMD_STATUS_READ, 16'h0000);
            req(panel_bus_pkg::CMD_MEMORY_READ, 16'h0000);
        end
        req_valid_i <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        `CHK(boost_enable_o, boost_on_i)
        `CHK(panel_reset_b_o, 1'b1)
        `CHK(init_done_o, 1'b1)
        panel_reinit_i <= 1'b1;
        @(posedge sys_clk_i);
        panel_reinit_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        `CHK(panel_reset_b_o, 1'b0)
        `CHK(init_done_o, 1'b0)
        req(panel_bus_pkg::CMD_STATUS_READ, 16'h0000);
        req(panel_bus_pkg::CMD_MEMORY_READ, 16'h0000);
        req_valid_i <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
        `CHK(expq.size(), 0)
        give_verdict();
    end
endmodule
bind display_parallel_bus_master display_parallel_bus_master_assertions u_chk (.*);
